// ==== common/fhc_map.vh ====
// Constants for the frequency-shift hop control block
// Function
// [RL1] Hop enable turns off other modulation mode
// [RL2] Sweep enable turns off hop mode
// [RL3] Carrier setting 10 mHz-15 MHz, default 1 kHz
// [RL4] Hop setting same range, default 100 Hz
// [RL5] Arbitrary maximum frequency follows point count
// [RL6] Built-in arbitrary waveforms capped at 5 MHz
// [RL7] External low selects carrier, high selects hop
// [RL8] Trigger lines use inverted level sense
// [RL9] Sync pulse above 200 ns entering hop
// [RL10] Hop rate 10 mHz-50 kHz, default 10 Hz
// [RL11] Internal source alternates at hop rate
// [RL12] External source ignores hop rate
// [RL13] Trigger source picks front input or line
// [RL14] Software enables hop after other setup
// [RL15] External level passes two-stage synchroniser
`ifndef FHC_MAP_VH
`define FHC_MAP_VH
// ============================================================
// Frequency settings in units of 10 mHz, 32 bits
// Millihertz would need 34 bits to reach 15 MHz; 10 mHz is the lower bound
`define FHC_FREQ_MIN        32'h00000001
`define FHC_FREQ_MAX        32'h59682F00
`define FHC_FREQ_MAX_TRI    32'h00989680
`define FHC_FREQ_ARB_8K     32'h1DCD6500
`define FHC_FREQ_ARB_12K    32'h0EE6B280
`define FHC_FREQ_ARB_BIG    32'h01312D00
`define FHC_FREQ_BUILTIN    32'h1DCD6500
`define FHC_CARRIER_DEF     32'h000186A0
`define FHC_HOP_DEF         32'h00002710
`define FHC_RATE_MAX        32'h004C4B40
`define FHC_RATE_DEF        32'h000003E8
// ============================================================
// Arbitrary point count thresholds
`define FHC_ARB_PTS_8K      16'h2000
`define FHC_ARB_PTS_12K     16'h2FFF
// ============================================================
// Shapes
`define FHC_SHAPE_SINE      3'h0
`define FHC_SHAPE_SQUARE    3'h1
`define FHC_SHAPE_TRI       3'h2
`define FHC_SHAPE_RAMP      3'h3
`define FHC_SHAPE_ARB       3'h4
`define FHC_SHAPE_BUILTIN   3'h5
// ============================================================
// Trigger source codes: 0 front input, 8..15 trigger lines 0..7
`define FHC_TSRC_FRONT      4'h0
`define FHC_TSRC_LINE_BIT   3
// ============================================================
// Modulation mode codes
`define FHC_MODE_NONE       3'h0
`define FHC_MODE_HOP        3'h4
`define FHC_MODE_SWEEP      3'h5
// ============================================================
// Timing: sync pulse, strictly above 200 ns
`define FHC_SYNC_NS         200
`define FHC_CLK_NS          10
`define FHC_SYNC_CYC        (`FHC_SYNC_NS / `FHC_CLK_NS + 1)
// Rate phase accumulator: clock rate in units of 10 mHz
`define FHC_CLK_FREQ_UNITS  40'h02540BE400
`endif

// ==== hdl/fhc_freq_limit.v ====
// Clamps one requested frequency to the range its waveform allows
`timescale 1ns/10ps
`include "fhc_map.vh"
module fhc_freq_limit (
   input  wire [31:0] reqFreq,   // Requested frequency, 10 mHz units
   input  wire [2:0]  shape,     // Waveform shape
   input  wire [15:0] arbPoints, // Arbitrary point count
   output reg  [31:0] limFreq    // Clamped frequency, 10 mHz units
);
   reg [31:0] maxFreq;
   always @* begin
      maxFreq = `FHC_FREQ_MAX;                                  // [RL3]
      case (shape)
         `FHC_SHAPE_TRI, `FHC_SHAPE_RAMP: maxFreq = `FHC_FREQ_MAX_TRI; // [RL3]
         `FHC_SHAPE_ARB: begin
            if (arbPoints <= `FHC_ARB_PTS_8K)
               maxFreq = `FHC_FREQ_ARB_8K;                      // [RL5]
            else if (arbPoints <= `FHC_ARB_PTS_12K)
               maxFreq = `FHC_FREQ_ARB_12K;                     // [RL5]
            else
               maxFreq = `FHC_FREQ_ARB_BIG;                     // [RL5]
         end
         `FHC_SHAPE_BUILTIN: maxFreq = `FHC_FREQ_BUILTIN;       // [RL6]
         default: maxFreq = `FHC_FREQ_MAX;
      endcase
      if (reqFreq < `FHC_FREQ_MIN)
         limFreq = `FHC_FREQ_MIN;
      else if (reqFreq > maxFreq)
         limFreq = maxFreq;
      else
         limFreq = reqFreq;
   end
endmodule

// ==== hdl/fhc_hop_control.v ====
// Frequency-shift hop control: mode exclusion, hop pacing, sync pulse
`timescale 1ns/10ps
`include "fhc_map.vh"
module fhc_hop_control #(
   parameter SYNC_CYC = `FHC_SYNC_CYC  // Sync pulse length, cycles
) (
   input  wire        clk,            // 100 MHz clock
   input  wire        reset_n,        // Async reset, active low
   input  wire        hopEnableReq,   // Pulse: enable hop mode
   input  wire        hopDisableReq,  // Pulse: disable hop mode
   input  wire        sweepEnableReq, // Pulse: enable sweep mode
   input  wire        otherModeReq,   // Pulse: enable another mode
   input  wire [2:0]  otherModeCode,  // Code of that other mode
   input  wire        configReset,    // Pulse: restore defaults
   input  wire        carrierWrite,   // Pulse: load carrier setting
   input  wire        hopFreqWrite,   // Pulse: load hop setting
   input  wire        rateWrite,      // Pulse: load hop rate
   input  wire [31:0] writeData,      // Setting value, 10 mHz units
   input  wire [2:0]  shape,          // Waveform shape
   input  wire [15:0] arbPoints,      // Arbitrary point count
   input  wire        hopSourceExt,   // Hop source: 1 external
   input  wire [3:0]  triggerSource,  // Trigger source select
   input  wire        extControl,     // Front-panel control pin
   input  wire [7:0]  triggerLines,   // Backplane trigger lines
   output reg  [2:0]  activeMode,     // Active modulation mode
   output reg  [31:0] carrierFreq,    // Carrier setting, 10 mHz units
   output reg  [31:0] hopFreq,        // Hop setting, 10 mHz units
   output reg  [31:0] hopRate,        // Hop rate, 10 mHz units
   output reg  [31:0] outFreq,        // Frequency now output, 10 mHz units
   output reg         hopSelected,    // 1 while hop frequency out
   output reg         syncOut         // Sync pulse
);
   // ============================================================
   // Mode codes
   localparam [2:0] MODE_NONE  = `FHC_MODE_NONE;
   localparam [2:0] MODE_HOP   = `FHC_MODE_HOP;
   localparam [2:0] MODE_SWEEP = `FHC_MODE_SWEEP;

   // ============================================================
   // Setting clamps
   // Carrier and hop share one clamp: both load from the same write
   // data with the same waveform in use.
   wire [31:0] limFreq;
   fhc_freq_limit uLimit (
      .reqFreq   (writeData),
      .shape     (shape),
      .arbPoints (arbPoints),
      .limFreq   (limFreq)
   );
   reg  [31:0] limRate;
   always @* begin
      if (writeData < `FHC_FREQ_MIN)
         limRate = `FHC_FREQ_MIN;                              // [RL10]
      else if (writeData > `FHC_RATE_MAX)
         limRate = `FHC_RATE_MAX;                              // [RL10]
      else
         limRate = writeData;
   end

   // ============================================================
   // Mode selection
   // Sweep outranks hop, so a same-cycle collision never leaves both on
   reg  [2:0]  next_activeMode;
   always @* begin
      next_activeMode = activeMode;
      if (configReset)
         next_activeMode = MODE_NONE;
      else if (sweepEnableReq)
         next_activeMode = MODE_SWEEP;                         // [RL2]
      else if (hopEnableReq)
         next_activeMode = MODE_HOP;                           // [RL1]
      else if (otherModeReq)
         next_activeMode = otherModeCode;                      // [RL1]
      else if (hopDisableReq && activeMode == MODE_HOP)
         next_activeMode = MODE_NONE;
   end
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         activeMode <= MODE_NONE;
      else
         activeMode <= next_activeMode;
   end

   // ============================================================
   // Stored settings
   reg  [31:0] next_carrierFreq;
   reg  [31:0] next_hopFreq;
   reg  [31:0] next_hopRate;
   always @* begin
      next_carrierFreq = carrierFreq;
      next_hopFreq     = hopFreq;
      next_hopRate     = hopRate;
      if (configReset) begin
         next_carrierFreq = `FHC_CARRIER_DEF;                  // [RL3]
         next_hopFreq     = `FHC_HOP_DEF;                      // [RL4]
         next_hopRate     = `FHC_RATE_DEF;                     // [RL10]
      end else begin
         if (carrierWrite)
            next_carrierFreq = limFreq;                        // [RL3] [RL5] [RL6]
         if (hopFreqWrite)
            next_hopFreq = limFreq;                            // [RL4] [RL5] [RL6]
         if (rateWrite)
            next_hopRate = limRate;                            // [RL10]
      end
   end
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         carrierFreq <= `FHC_CARRIER_DEF;
         hopFreq     <= `FHC_HOP_DEF;
         hopRate     <= `FHC_RATE_DEF;
      end else begin
         carrierFreq <= next_carrierFreq;
         hopFreq     <= next_hopFreq;
         hopRate     <= next_hopRate;
      end
   end

   // ============================================================
   // External level synchronisers
   // Only the second stage is read, so a metastable first stage never
   // reaches the selection logic.
   reg  [8:0]  syncA;
   reg  [8:0]  syncB;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA <= 9'h000;
         syncB <= 9'h000;
      end else begin
         syncA <= {triggerLines, extControl};                  // [RL15]
         syncB <= syncA;                                       // [RL15]
      end
   end

   // ============================================================
   // External level selection
   // Backplane lines carry the opposite sense to the front-panel pin
   reg         extHop;
   always @* begin
      case (triggerSource)
         4'h8:    extHop = ~syncB[1];                          // [RL8] [RL13]
         4'h9:    extHop = ~syncB[2];                          // [RL8] [RL13]
         4'hA:    extHop = ~syncB[3];                          // [RL8] [RL13]
         4'hB:    extHop = ~syncB[4];                          // [RL8] [RL13]
         4'hC:    extHop = ~syncB[5];                          // [RL8] [RL13]
         4'hD:    extHop = ~syncB[6];                          // [RL8] [RL13]
         4'hE:    extHop = ~syncB[7];                          // [RL8] [RL13]
         4'hF:    extHop = ~syncB[8];                          // [RL8] [RL13]
         default: extHop = syncB[0];                           // [RL7] [RL13]
      endcase
   end

   // ============================================================
   // Internal rate generator
   // The accumulator adds twice the rate, so each wrap marks one half
   // period and toggles the hop level once.
   // Limitation: rate resolution is one setting unit, 10 mHz.
   wire        hopOn    = (activeMode == MODE_HOP);
   wire        rateRun  = hopOn & ~hopSourceExt;
   reg  [39:0] phase;
   reg         intHop;
   wire [39:0] rateStep = {7'h00, hopRate, 1'b0};
   wire [40:0] sumPhase = {1'b0, phase} + {1'b0, rateStep};
   wire        rateWrap = (sumPhase >= {1'b0, `FHC_CLK_FREQ_UNITS});
   reg  [39:0] next_phase;
   reg         next_intHop;
   always @* begin
      next_phase  = sumPhase[39:0];
      next_intHop = intHop;
      if (!rateRun) begin
         next_phase  = 40'h0000000000;                         // [RL12]
         next_intHop = 1'b0;
      end else if (rateWrap) begin
         next_phase  = sumPhase[39:0] - `FHC_CLK_FREQ_UNITS;
         next_intHop = ~intHop;                                // [RL11]
      end
   end
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase  <= 40'h0000000000;
         intHop <= 1'b0;
      end else begin
         phase  <= next_phase;
         intHop <= next_intHop;
      end
   end

   // ============================================================
   // Frequency selection
   wire        next_hopSelected = hopOn & (hopSourceExt ? extHop : intHop);
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hopSelected <= 1'b0;
         outFreq     <= `FHC_CARRIER_DEF;
      end else begin
         hopSelected <= next_hopSelected;                      // [RL7] [RL11]
         outFreq     <= next_hopSelected ? hopFreq : carrierFreq;
      end
   end

   // ============================================================
   // Sync pulse
   // A fresh entry into hop restarts the count, so a fast hop source
   // stretches the pulse rather than cutting it below the minimum.
   wire        hopEntry = next_hopSelected & ~hopSelected;
   reg  [7:0]  syncCount;
   reg  [7:0]  next_syncCount;
   reg         next_syncOut;
   always @* begin
      next_syncCount = syncCount;
      next_syncOut   = syncOut;
      if (hopEntry) begin
         next_syncOut   = 1'b1;                                // [RL9]
         next_syncCount = SYNC_CYC[7:0] - 8'h01;
      end else if (syncCount != 8'h00) begin
         next_syncCount = syncCount - 8'h01;
      end else begin
         next_syncOut = 1'b0;
      end
   end
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncOut   <= 1'b0;
         syncCount <= 8'h00;
      end else begin
         syncOut   <= next_syncOut;
         syncCount <= next_syncCount;
      end
   end
endmodule

// ==== dv/fhc_ext_src.sv ====
// External level source that steers hop selection
`timescale 1ns/10ps
module fhc_ext_src (
   input  logic       clk,                  // Bench clock
   input  logic       hopWant,              // 1 asks for hop frequency
   input  logic [3:0] src,                  // Input the device listens to
   output logic       extControl = 1'b0,    // Front-panel level
   output logic [7:0] triggerLines = 8'h00  // Backplane lines
);
   // ============================================================
   // Unselected inputs toggle every cycle so a wrong pick shows
   always @(posedge clk) begin
      extControl <= ~extControl;
      triggerLines <= ~triggerLines;
      if (src[3])
         triggerLines[src[2:0]] <= ~hopWant;
      else
         extControl <= hopWant;
   end
endmodule

// ==== dv/fhc_chk_chk.sv ====
// Port checks for the hop control block
`timescale 1ns/10ps
`include "fhc_map.vh"
module fhc_chk #(parameter int SYNC_CYC = 21) (
   input logic        clk, reset_n, hopEnableReq, sweepEnableReq, configReset, rateWrite,
   input logic        hopSourceExt, extControl, hopSelected, syncOut,
   input logic [31:0] writeData, carrierFreq, hopFreq, hopRate, outFreq,
   input logic [3:0]  triggerSource,
   input logic [7:0]  triggerLines,
   input logic [2:0]  activeMode
);
   // ============================================================
   // Assertions
   localparam int SYNC_LAST = SYNC_CYC - 1;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_hop_mode: assert property (
      hopEnableReq && !sweepEnableReq && !configReset |=> activeMode == 3'h4) else $error("hop");
   a_sweep_mode: assert property (
      sweepEnableReq && !configReset |=> activeMode == 3'h5) else $error("sweep");
   a_cfg_defaults: assert property (
      configReset |=> activeMode == 3'h0 && hopRate == `FHC_RATE_DEF
      && carrierFreq == `FHC_CARRIER_DEF && hopFreq == `FHC_HOP_DEF) else $error("defaults");
   a_rate_clamp: assert property (
      rateWrite && !configReset |=> hopRate == ($past(writeData) < `FHC_FREQ_MIN ? `FHC_FREQ_MIN
      : $past(writeData) > `FHC_RATE_MAX ? `FHC_RATE_MAX : $past(writeData))) else $error("rate");
   a_sync_on_hop: assert property (
      $rose(hopSelected) |-> syncOut) else $error("sync start");
   // Cycles since the last entry into hop; a new entry restarts the pulse
   int sinceHop;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         sinceHop <= 1000;
      else if ($rose(hopSelected))
         sinceHop <= 0;
      else if (sinceHop < 1000)
         sinceHop <= sinceHop + 1;
   end
   a_sync_width: assert property (
      !$rose(hopSelected) |-> syncOut == (sinceHop < SYNC_LAST)) else $error("sync width");
   a_front_level: assert property (
      (activeMode == 3'h4 && hopSourceExt && triggerSource == 4'h0 && $stable(extControl))[*5]
      |-> hopSelected == extControl) else $error("front level");
   a_line_level: assert property (
      (activeMode == 3'h4 && hopSourceExt && triggerSource[3] && $stable(triggerSource)
      && $stable(triggerLines[triggerSource[2:0]]))[*5]
      |-> hopSelected == !triggerLines[triggerSource[2:0]]) else $error("line level");
   a_out_select: assert property (
      ($stable(hopSelected) && $stable(hopFreq) && $stable(carrierFreq))[*2]
      |-> outFreq == (hopSelected ? hopFreq : carrierFreq)) else $error("out freq");
endmodule

// ==== dv/fhc_tb.sv ====
// Self-checking bench for the hop control block
`timescale 1ns/10ps
`include "fhc_map.vh"
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin failures++; \
   $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module tb;
   logic        clk = 1'b0, reset_n = 1'b0, hopSourceExt = 1'b0, hopWant = 1'b0;
   logic        extControl, hopSelected, syncOut;
   logic [7:0]  req = 8'h00, triggerLines;
   logic [2:0]  otherModeCode = 3'h0, shape = 3'h0, activeMode;
   logic [3:0]  triggerSource = 4'h0;
   logic [15:0] arbPoints = 16'h0010;
   logic [31:0] writeData = 32'h0, rs = 32'h24, d, mx, n;
   logic [31:0] carrierFreq, hopFreq, hopRate, outFreq;
   int          failures = 0, nChecks = 0, cyc = 0, i, k;
   logic [15:0] pts [4] = '{16'h2000, 16'h2001, 16'h2FFF, 16'h3000};
   logic [2:0]  md [8] = '{3'h1, 3'h4, 3'h2, 3'h4, 3'h5, 3'h5, 3'h4, 3'h0};
   int          op [8] = '{3, 0, 3, 0, 2, 1, 0, 1};
   fhc_hop_control i_fhc_hop_control (.clk(clk), .reset_n(reset_n), .hopEnableReq(req[0]),
      .hopDisableReq(req[1]), .sweepEnableReq(req[2]), .otherModeReq(req[3]),
      .otherModeCode(otherModeCode), .configReset(req[4]), .carrierWrite(req[5]),
      .hopFreqWrite(req[6]), .rateWrite(req[7]), .writeData(writeData), .shape(shape),
      .arbPoints(arbPoints), .hopSourceExt(hopSourceExt), .triggerSource(triggerSource),
      .extControl(extControl), .triggerLines(triggerLines), .activeMode(activeMode),
      .carrierFreq(carrierFreq), .hopFreq(hopFreq), .hopRate(hopRate), .outFreq(outFreq),
      .hopSelected(hopSelected), .syncOut(syncOut));
   fhc_ext_src i_fhc_ext_src (.clk(clk), .hopWant(hopWant), .src(triggerSource),
      .extControl(extControl), .triggerLines(triggerLines));
   // ============================================================
   // Helpers
   function automatic [31:0] fmax(input [2:0] s, input [15:0] p);
      if (s == `FHC_SHAPE_TRI || s == `FHC_SHAPE_RAMP) return `FHC_FREQ_MAX_TRI;
      if (s == `FHC_SHAPE_BUILTIN) return `FHC_FREQ_BUILTIN;
      if (s != `FHC_SHAPE_ARB) return `FHC_FREQ_MAX;
      return p <= `FHC_ARB_PTS_8K ? `FHC_FREQ_ARB_8K
         : (p <= `FHC_ARB_PTS_12K ? `FHC_FREQ_ARB_12K : `FHC_FREQ_ARB_BIG);
   endfunction
   function automatic [31:0] lim(input [31:0] v, input [31:0] m);
      return v < `FHC_FREQ_MIN ? `FHC_FREQ_MIN : (v > m ? m : v);
   endfunction
   function [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task pulse(input int b, input [31:0] v);
      @(posedge clk);
      req[b] <= 1'b1;
      writeData <= v;
      otherModeCode <= v[2:0];
      @(posedge clk);
      req <= 8'h00;
      #1;
   endtask
   task waitSel(input logic v);
      for (k = 0; k < 3000 && hopSelected !== v; k++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task give_verdict();
      if (failures == 0 && nChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
   end
   // ============================================================
   // Scenarios
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      `CHK({carrierFreq, hopFreq, hopRate}, {`FHC_CARRIER_DEF, `FHC_HOP_DEF, `FHC_RATE_DEF})
      for (i = 0; i < 24; i++) begin
         @(posedge clk);
         shape <= 3'(i % 6);
         arbPoints <= pts[i / 6];
         #1;
         mx = fmax(shape, arbPoints);
         d = (i % 4 == 0) ? 32'h00000000 : (i % 4 == 1) ? mx : (i % 4 == 2) ? mx + 1 : rnd();
         pulse(5, d);
         `CHK(carrierFreq, lim(d, mx))
         pulse(6, ~d);
         `CHK(hopFreq, lim(~d, mx))
         pulse(7, d);
         `CHK(hopRate, lim(d, `FHC_RATE_MAX))
      end
      pulse(4, 32'h0);
      for (i = 0; i < 8; i++) begin
         pulse(op[i], 32'h1 + i / 2);
         `CHK(activeMode, md[i])
      end
      pulse(7, `FHC_RATE_MAX);
      pulse(0, 32'h0);
      waitSel(1'b0);
      waitSel(1'b1);
      for (n = 0; syncOut === 1'b1 && n < 99; n++) begin
         @(posedge clk);
         #1;
      end
      `CHK(n, 32'(`FHC_SYNC_CYC))
      waitSel(1'b0);
      for (n = 0; hopSelected === 1'b0 && n < 3000; n++) begin
         @(posedge clk);
         #1;
      end
      `CHK(n, 32'(`FHC_CLK_FREQ_UNITS / (2 * `FHC_RATE_MAX)))
      @(posedge clk);
      hopSourceExt <= 1'b1;
      pulse(7, rnd());
      for (i = 0; i < 18; i++) begin
         d = rnd();
         @(posedge clk);
         triggerSource <= (i < 2) ? 4'h0 : 4'(7 + i / 2);
         hopWant <= d[0];
         repeat ((i == 1) ? 1500 : 6) @(posedge clk);
         #1;
         `CHK(hopSelected, hopWant)
         `CHK(outFreq, hopWant ? `FHC_HOP_DEF : `FHC_CARRIER_DEF)
      end
      give_verdict();
   end
endmodule
bind fhc_hop_control fhc_chk #(.SYNC_CYC(SYNC_CYC)) i_fhc_chk (.*);
